// ==== rri_chk.sv ====
// Purpose: port assertions for rri_top
// Assumes: one clock domain, APB master keeps the protocol
// Notes: interrupt enable is not visible here, vectoring is checked in the bench
`timescale 1ns/10ps
`include "rri_params.svh"
module rri_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Events and core view
   input wire logic hold_reset,
   input wire logic wake_pulse,
   input wire logic wake_by_irq,
   input wire logic init_pulse,
   input wire logic core_run,
   input wire logic [7:0] pc_out
);
   // ------------------------------------------------
   // Properties
   // ------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic bad_addr;
   assign bad_addr = (paddr[7:2] > `RRI_INFO) || (paddr[1:0] != 2'b00);
   chk_ready_time: assert property (psel && penable && !pready |=> pready) else $error("pready late");
   chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
   chk_err_addr: assert property (pready |-> pslverr == bad_addr) else $error("pslverr wrong");
   chk_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits set");
   chk_run_follow: assert property (1'b1 |=> core_run == !$past(hold_reset)) else $error("core_run wrong");
   chk_release_init: assert property ($fell(hold_reset) |=> init_pulse) else $error("no init at release");
   chk_hold_quiet: assert property (hold_reset |=> !init_pulse) else $error("init while held");
   chk_release_pc: assert property ($fell(hold_reset) |=> pc_out == 8'h00) else $error("pc not zero");
   // Wake in the release cycle is refused, hence the past terms
   chk_wake_pc: assert property (wake_pulse && !wake_by_irq && !hold_reset && !$past(hold_reset)
      && $past(presetn) |=> pc_out == $past(pc_out) + 8'h01) else $error("wake pc wrong");
   chk_wake_init: assert property (wake_pulse && !hold_reset && !$past(hold_reset) && $past(presetn)
      |=> init_pulse) else $error("no init on wake");
   cover property (wake_pulse && wake_by_irq);
   cover property ($fell(hold_reset));
   cover property (pready && pslverr);
endmodule : rri_chk
bind rri_top rri_chk rri_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
   .pslverr, .hold_reset, .wake_pulse, .wake_by_irq, .init_pulse, .core_run, .pc_out);

// ==== rri_params.svh ====
// Purpose: constants for the register reset initializer
// Assumes: registers are 8 bits, one per 32-bit APB word
// Notes: x bits of the power-up image load as zero
// Functional notes
// - Program counter low zeroed; wake gives pc+1
// - Interrupt wake with enable set vectors
// - Interrupt wake leaves its source flag set
// - Status image depends on reset cause
// - Irq control cleared, bit0 kept on clear
// - Option and port b-d direction set ones
// - Timer 2 period ones on every class
// - Port a direction six ones, held wake
// - Port e direction 0000_-111, bit3 zero
// - Upper latch five bits cleared, held wake
// - Port a data cleared, bit4 kept clear
// - Receive status power and clear images
// - Transmit status 0000_-010 on resets
// - Timer 1 control cleared on power only
// - Timer 2 control seven bits cleared
// - Converter control zero cleared, bit1 zero
// - Timer2 count, serial, address, baud cleared
// - Flag and enable one low bits cleared
// - Unknown group kept by clear-class resets, zeroed by brown-out
// - Unimplemented and reserved bits read zero
// - Power-on flag cleared by power-on only
`ifndef RRI_PARAMS_SVH
`define RRI_PARAMS_SVH
// ------------------------------------------------
// Register indices, byte address is four times
// ------------------------------------------------
`define RRI_WORKING 6'h00
`define RRI_TIMER0 6'h01
`define RRI_PC_LOW 6'h02
`define RRI_STATUS 6'h03
`define RRI_PTR 6'h04
`define RRI_PA_DATA 6'h05
`define RRI_PB_DATA 6'h06
`define RRI_PC_DATA 6'h07
`define RRI_PD_DATA 6'h08
`define RRI_PCLATCH 6'h09
`define RRI_IRQCTL 6'h0a
`define RRI_FLAGS1 6'h0b
`define RRI_FLAGS2 6'h0c
`define RRI_T1CTL 6'h0d
`define RRI_T2CNT 6'h0e
`define RRI_T2CTL 6'h0f
`define RRI_SSCTL 6'h10
`define RRI_CAPLO 6'h11
`define RRI_CAPHI 6'h12
`define RRI_RXSTAT 6'h13
`define RRI_CONVRES 6'h14
`define RRI_CONVCTL 6'h15
`define RRI_OPTION 6'h16
`define RRI_PA_DIR 6'h17
`define RRI_PB_DIR 6'h18
`define RRI_PC_DIR 6'h19
`define RRI_PD_DIR 6'h1a
`define RRI_PE_DIR 6'h1b
`define RRI_ENABLES1 6'h1c
`define RRI_CAUSE 6'h1d
`define RRI_T2PER 6'h1e
`define RRI_SSADDR 6'h1f
`define RRI_TXSTAT 6'h20
`define RRI_BAUD 6'h21
`define RRI_INFO 6'h22
`define RRI_NREG 34
// ------------------------------------------------
// Field positions and images
// ------------------------------------------------
`define RRI_TO_BIT 4
`define RRI_PD_BIT 3
`define RRI_IRQ_EN_BIT 7
`define RRI_POR_FLAG_BIT 1
`define RRI_BOR_FLAG_BIT 0
`define RRI_VECTOR 8'h04
`define RRI_ONES 8'hff
`define RRI_ZERO 8'h00
`define RRI_STATUS_POR 8'h18
`define RRI_MASK6 8'h3f
`define RRI_MASK5 8'h1f
`define RRI_MASK7 8'h7f
`define RRI_MASK1 8'h01
`define RRI_MASK2 8'h03
`define RRI_PE_DIR_MASK 8'hf7
`define RRI_PE_DIR_RST 8'h07
`define RRI_PA_DATA_KEEP 8'h10
`define RRI_RX_MASK 8'hef
`define RRI_TX_MASK 8'hf7
`define RRI_TX_RST 8'h02
`define RRI_CONV_MASK 8'hfd
`endif

// ==== rri_pkg.sv ====
// Purpose: types of the register reset initializer
// Assumes: rri_params.svh holds the numbers
// Notes: none
package rri_pkg;
`include "rri_params.svh"
   typedef enum logic [2:0] {
      RRI_POR = 3'b000,
      RRI_BOR = 3'b001,
      RRI_CLR_RUN = 3'b010,
      RRI_CLR_SLEEP = 3'b011,
      RRI_DOG_RESET = 3'b100
   } rri_cause_e;
   typedef enum logic [1:0] {
      RRI_CL_POWER = 2'b00,
      RRI_CL_CLEAR = 2'b01,
      RRI_CL_WAKE = 2'b10,
      RRI_CL_NONE = 2'b11
   } rri_class_e;
   typedef struct packed {
      logic [7:0] impl;
      logic [7:0] por;
      logic [7:0] clr;
      logic [7:0] keep;
   } rri_init_s;
   typedef struct packed {
      logic [`RRI_NREG-1:0][7:0] regs;
      logic held;
      rri_cause_e cause;
      rri_class_e last_class;
      rri_cause_e last_cause;
      logic init_pulse;
      logic run;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } rri_state_s;
endpackage : rri_pkg

// ==== rri_top.sv ====
// Purpose: loads special register images per reset or wake class
// Assumes: cause and wake inputs come from same-clock detector logic
// Notes: registers readable and writable over APB, info word read only
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "rri_params.svh"
module rri_top (
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Reset cause detectors
   input wire logic hold_reset,
   input wire logic [2:0] reset_cause,
   // Wake-up from sleep
   input wire logic wake_pulse,
   input wire logic wake_by_irq,
   input wire logic [1:0] wake_flag_reg,
   input wire logic [2:0] wake_flag_bit,
   // Core view
   output logic core_run,
   output logic init_pulse,
   output logic [7:0] pc_out
);

   // ------------------------------------------------
   // Per-register images
   // ------------------------------------------------
   function automatic rri_pkg::rri_init_s init_of(input logic [5:0] idx);
      rri_pkg::rri_init_s r;
      r = '{impl: `RRI_ONES, por: `RRI_ZERO, clr: `RRI_ZERO, keep: `RRI_ZERO};
      case (idx)
         `RRI_WORKING, `RRI_TIMER0, `RRI_PTR, `RRI_PB_DATA, `RRI_PC_DATA, `RRI_PD_DATA,
         `RRI_CAPLO, `RRI_CAPHI, `RRI_CONVRES: begin
            r.keep = `RRI_ONES;
         end
         `RRI_OPTION, `RRI_PB_DIR, `RRI_PC_DIR, `RRI_PD_DIR, `RRI_T2PER: begin
            r.por = `RRI_ONES;
            r.clr = `RRI_ONES;
         end
         `RRI_PA_DIR: begin
            r.impl = `RRI_MASK6;
            r.por = `RRI_MASK6;
            r.clr = `RRI_MASK6;
         end
         `RRI_PE_DIR: begin
            r.impl = `RRI_PE_DIR_MASK;
            r.por = `RRI_PE_DIR_RST;
            r.clr = `RRI_PE_DIR_RST;
         end
         `RRI_PCLATCH: begin
            r.impl = `RRI_MASK5;
         end
         `RRI_IRQCTL: begin
            r.keep = `RRI_MASK1;
         end
         `RRI_FLAGS1, `RRI_ENABLES1: begin
            r.impl = `RRI_MASK7;
         end
         `RRI_FLAGS2: begin
            r.impl = `RRI_MASK1;
         end
         `RRI_PA_DATA: begin
            r.impl = `RRI_MASK6;
            r.keep = `RRI_PA_DATA_KEEP;
         end
         `RRI_RXSTAT: begin
            r.impl = `RRI_RX_MASK;
            r.keep = `RRI_MASK1;
         end
         `RRI_TXSTAT: begin
            r.impl = `RRI_TX_MASK;
            r.por = `RRI_TX_RST;
            r.clr = `RRI_TX_RST;
         end
         `RRI_T1CTL: begin
            r.impl = `RRI_MASK6;
            r.keep = `RRI_MASK6;
         end
         `RRI_T2CTL: begin
            r.impl = `RRI_MASK7;
         end
         `RRI_CONVCTL: begin
            r.impl = `RRI_CONV_MASK;
         end
         `RRI_CAUSE: begin
            r.impl = `RRI_MASK2;
            r.keep = `RRI_MASK2;
         end
         `RRI_STATUS: begin
            r.por = `RRI_STATUS_POR;
         end
         default: begin
            r.impl = `RRI_ONES;
         end
      endcase
      return r;
   endfunction : init_of

   function automatic logic [5:0] flag_index(input logic [1:0] sel);
      case (sel)
         2'b00: flag_index = `RRI_IRQCTL;
         2'b01: flag_index = `RRI_FLAGS1;
         default: flag_index = `RRI_FLAGS2;
      endcase
   endfunction : flag_index

   // ------------------------------------------------
   // State
   // ------------------------------------------------
   localparam rri_pkg::rri_state_s RRI_ST_RST = '{
      regs: '0,
      held: 1'b1,
      cause: rri_pkg::RRI_POR,
      last_class: rri_pkg::RRI_CL_NONE,
      last_cause: rri_pkg::RRI_POR,
      init_pulse: 1'b0,
      run: 1'b0,
      pready: 1'b0,
      pslverr: 1'b0,
      prdata: 32'h0000_0000
   };

   rri_pkg::rri_state_s st_ff;
   rri_pkg::rri_state_s nxt_st;

   logic [5:0] bus_idx;
   logic bus_hit;
   logic release_now;
   logic [7:0] imm;

   assign bus_idx = paddr[7:2];
   assign bus_hit = (paddr[1:0] == 2'b00) && (bus_idx <= `RRI_INFO);
   assign release_now = st_ff.held & ~hold_reset;

   // ------------------------------------------------
   // Next state
   // ------------------------------------------------
   always_comb begin
      rri_pkg::rri_init_s ini;
      logic [7:0] st_old;
      logic [5:0] fidx;
      ini = '0;
      st_old = st_ff.regs[`RRI_STATUS];
      fidx = flag_index(wake_flag_reg);
      imm = 8'h00;
      nxt_st = st_ff;
      nxt_st.init_pulse = 1'b0;
      nxt_st.pready = 1'b0;
      nxt_st.pslverr = 1'b0;
      nxt_st.held = hold_reset;
      nxt_st.run = ~hold_reset;
      if (hold_reset) begin
         nxt_st.cause = rri_pkg::rri_cause_e'(reset_cause);
      end
      // One wait state: pready answers on the second access cycle
      if (psel & penable & ~st_ff.pready) begin
         nxt_st.pready = 1'b1;
         nxt_st.pslverr = ~bus_hit;
         nxt_st.prdata = 32'h0000_0000;
         if (bus_hit && bus_idx == `RRI_INFO) begin
            nxt_st.prdata = {27'h000_0000, st_ff.last_class, st_ff.last_cause};
         end else if (bus_hit) begin
            ini = init_of(bus_idx);
            imm = ini.impl;
            nxt_st.prdata = {24'h00_0000, st_ff.regs[bus_idx] & imm};
            if (pwrite) begin
               nxt_st.regs[bus_idx] = pwdata[7:0] & imm;
            end
         end
      end
      // Reset release overrides a software write of the same cycle, except kept bits on a clear cause
      if (release_now) begin
         for (int i = 0; i < `RRI_NREG; i++) begin
            ini = init_of(6'(i));
            if (st_ff.cause == rri_pkg::RRI_POR || st_ff.cause == rri_pkg::RRI_BOR) begin
               nxt_st.regs[i] = ini.por;
            end else begin
               nxt_st.regs[i] = (ini.clr & ~ini.keep) | (nxt_st.regs[i] & ini.keep);
            end
         end
         nxt_st.regs[`RRI_PC_LOW] = `RRI_ZERO;
         case (st_ff.cause)
            rri_pkg::RRI_POR: begin
               nxt_st.regs[`RRI_STATUS] = `RRI_STATUS_POR;
               nxt_st.regs[`RRI_CAUSE][`RRI_POR_FLAG_BIT] = 1'b0;
               nxt_st.regs[`RRI_CAUSE][`RRI_BOR_FLAG_BIT] = 1'b0;
            end
            rri_pkg::RRI_BOR: begin
               nxt_st.regs[`RRI_STATUS] = {3'b000, 1'b1, 1'b1, st_old[2:0]};
               nxt_st.regs[`RRI_CAUSE] = st_ff.regs[`RRI_CAUSE];
               nxt_st.regs[`RRI_CAUSE][`RRI_BOR_FLAG_BIT] = 1'b0;
            end
            rri_pkg::RRI_CLR_RUN: begin
               nxt_st.regs[`RRI_STATUS] = {3'b000, st_old[4:0]};
            end
            rri_pkg::RRI_CLR_SLEEP: begin
               nxt_st.regs[`RRI_STATUS] = {3'b000, 1'b1, 1'b0, st_old[2:0]};
            end
            default: begin
               nxt_st.regs[`RRI_STATUS] = {3'b000, 1'b0, 1'b1, st_old[2:0]};
            end
         endcase
         nxt_st.last_cause = st_ff.cause;
         nxt_st.last_class = (st_ff.cause == rri_pkg::RRI_POR || st_ff.cause == rri_pkg::RRI_BOR) ?
                             rri_pkg::RRI_CL_POWER : rri_pkg::RRI_CL_CLEAR;
         nxt_st.init_pulse = 1'b1;
      end else if (wake_pulse & ~st_ff.held & ~hold_reset) begin
         // Everything else holds: only these registers move on wake
         nxt_st.regs[`RRI_T2PER] = `RRI_ONES;
         nxt_st.regs[`RRI_STATUS][`RRI_PD_BIT] = 1'b0;
         nxt_st.regs[`RRI_STATUS][`RRI_TO_BIT] = wake_by_irq;
         if (wake_by_irq && nxt_st.regs[`RRI_IRQCTL][`RRI_IRQ_EN_BIT]) begin
            nxt_st.regs[`RRI_PC_LOW] = `RRI_VECTOR;
            nxt_st.regs[`RRI_IRQCTL][`RRI_IRQ_EN_BIT] = 1'b0;
         end else begin
            nxt_st.regs[`RRI_PC_LOW] = st_ff.regs[`RRI_PC_LOW] + 8'h01;
         end
         if (wake_by_irq) begin
            // Flag set is applied after the bus write so it wins over a clear
            ini = init_of(fidx);
            nxt_st.regs[fidx][wake_flag_bit] = ini.impl[wake_flag_bit];
         end
         nxt_st.last_class = rri_pkg::RRI_CL_WAKE;
         nxt_st.init_pulse = 1'b1;
      end
   end

   // ------------------------------------------------
   // Registers
   // ------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= RRI_ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign prdata = st_ff.prdata;
   assign pready = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign core_run = st_ff.run;
   assign init_pulse = st_ff.init_pulse;
   assign pc_out = st_ff.regs[`RRI_PC_LOW];

endmodule : rri_top

// ==== rri_top_tb_top.sv ====
// Purpose: directed bench for rri_top
// Assumes: APB answers within 20 cycles
// Notes: unknown image bits avoided where the load value is open
`timescale 1ns/10ps
`include "rri_params.svh"
module rri_top_tb_top;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd_data;
   logic pready, pslverr, core_run, init_pulse, rd_err;
   logic hold_reset = 1'b1, wake_pulse = 1'b0, wake_by_irq = 1'b0;
   logic [2:0] reset_cause = 3'h0, wake_flag_bit = 3'h0;
   logic [1:0] wake_flag_reg = 2'h0;
   logic [7:0] pc_out;
   int errors = 0;
   int checks_done = 0;
   int i;
   // ------------------------------------------------
   // Register table: index, write, read back, after watchdog reset
   // ------------------------------------------------
   logic [5:0] ti [17] = '{`RRI_WORKING, `RRI_OPTION, `RRI_PA_DIR, `RRI_PE_DIR, `RRI_PCLATCH, `RRI_PA_DATA,
      `RRI_RXSTAT, `RRI_TXSTAT, `RRI_T1CTL, `RRI_T2CTL, `RRI_CONVCTL, `RRI_T2CNT, `RRI_BAUD, `RRI_FLAGS1,
      `RRI_T2PER, `RRI_IRQCTL, `RRI_CAUSE};
   logic [7:0] tw [17] = '{8'ha5, 8'h5a, 8'h00, 8'hff, 8'hff, 8'hff, 8'hee, 8'hff, 8'hff, 8'hff, 8'hff,
      8'h55, 8'h55, 8'h7f, 8'h12, 8'hff, 8'hff};
   logic [7:0] tm [17] = '{8'ha5, 8'h5a, 8'h00, 8'hf7, 8'h1f, 8'h3f, 8'hee, 8'hf7, 8'h3f, 8'h7f, 8'hfd,
      8'h55, 8'h55, 8'h7f, 8'h12, 8'hff, 8'h03};
   logic [7:0] tc [17] = '{8'ha5, 8'hff, 8'h3f, 8'h07, 8'h00, 8'h10, 8'h00, 8'h02, 8'h3f, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'hff, 8'h01, 8'h03};
   always #10 pclk = ~pclk;
   rri_top rri_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .hold_reset, .reset_cause, .wake_pulse, .wake_by_irq, .wake_flag_reg, .wake_flag_bit,
      .core_run, .init_pulse, .pc_out);
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) errors++;
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [5:0] x, input logic [7:0] d);
      apb(1'b1, {x, 2'b00}, d);
   endtask : wr
   task rc(input logic [5:0] x, input logic [7:0] e);
      apb(1'b0, {x, 2'b00}, 8'h00);
      cmp(rd_data, {24'h0, e});
   endtask : rc
   task rst(input logic [2:0] c);
      @(posedge pclk);
      hold_reset <= 1'b1;
      reset_cause <= c;
      repeat (3) @(posedge pclk);
      hold_reset <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask : rst
   task wk(input logic irq, input logic [1:0] r, input logic [2:0] b);
      @(posedge pclk);
      wake_pulse <= 1'b1;
      wake_by_irq <= irq;
      wake_flag_reg <= r;
      wake_flag_bit <= b;
      @(posedge pclk);
      wake_pulse <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask : wk
   task end_of_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   // ------------------------------------------------
   // Tests
   // ------------------------------------------------
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      hold_reset <= 1'b0;
      repeat (3) @(posedge pclk);
      rc(`RRI_STATUS, 8'h18);
      rc(`RRI_CAUSE, 8'h00);
      cmp({24'h0, pc_out}, 32'h0);
      $display("test power_on done");
      for (i = 0; i < 17; i++) begin
         wr(ti[i], tw[i]);
         rc(ti[i], tm[i]);
      end
      rst(3'd4);
      rc(`RRI_STATUS, 8'h08);
      for (i = 0; i < 17; i++) rc(ti[i], tc[i]);
      // Same loop also
      $display("test watchdog_reset done");
      wr(`RRI_PC_LOW, 8'h7f);
      wr(`RRI_OPTION, 8'h33);
      wr(`RRI_T2PER, 8'h12);
      wk(1'b0, 2'd1, 3'd0);
      cmp({24'h0, pc_out}, 32'h80);
      rc(`RRI_T2PER, 8'hff);
      rc(`RRI_OPTION, 8'h33);
      rc(`RRI_FLAGS1, 8'h00);
      rc(`RRI_STATUS, 8'h00);
      wr(`RRI_IRQCTL, 8'h80);
      wk(1'b1, 2'd0, 3'd1);
      cmp({24'h0, pc_out}, 32'h04);
      rc(`RRI_IRQCTL, 8'h02);
      rc(`RRI_STATUS, 8'h10);
      wk(1'b1, 2'd2, 3'd0);
      cmp({24'h0, pc_out}, 32'h05);
      rc(`RRI_FLAGS2, 8'h01);
      wk(1'b1, 2'd1, 3'd7);
      cmp({24'h0, pc_out}, 32'h06);
      rc(`RRI_FLAGS1, 8'h00);
      $display("test wake done");
      rst(3'd1);
      rc(`RRI_STATUS, 8'h18);
      rc(`RRI_CAUSE, 8'h02);
      rc(`RRI_T1CTL, 8'h00);
      rc(`RRI_PA_DATA, 8'h00);
      rst(3'd3);
      rc(`RRI_STATUS, 8'h10);
      rst(3'd2);
      rc(`RRI_STATUS, 8'h10);
      rst(3'd0);
      rc(`RRI_CAUSE, 8'h00);
      $display("test causes done");
      apb(1'b0, 8'h8c, 8'h00);
      cmp({31'h0, rd_err}, 32'h1);
      cmp(rd_data, 32'h0);
      apb(1'b1, 8'h09, 8'hff);
      cmp({31'h0, rd_err}, 32'h1);
      $display("test refusal done");
      end_of_test;
   end
   // Whole run is near 360 cycles, so 100 us only trips on a hang
   initial begin
      #100000;
      errors++;
      end_of_test;
   end
endmodule : rri_top_tb_top
